// ==== verilog/hsbp_pkg.sv ====
// constants, field layouts and carriers of the host serial burst port
// Overview of operation
// [RULE_01] shared card pins carry select, data, clock, interrupt
// [RULE_02] command, address, then optional length field
// [RULE_03] register write shifts in sixteen data bits
// [RULE_04] error byte follows every register write
// [RULE_05] register read: padding, error byte, data
// [RULE_06] command burst bit selects burst access
// [RULE_07] register cycles to registers, bursts to buffer
// [RULE_08] bursts move bytes, zero to 64 kilobytes
// [RULE_09] zero length burst moves no data
// [RULE_10] length field only when enable bit set
// [RULE_11] burst read padding from padding register
// [RULE_12] error byte then unbroken burst read data
// [RULE_13] burst read prefetches, address advances internally
// [RULE_14] chip select release ends burst without length
// [RULE_15] failed memory access raises host interrupt
// [RULE_16] transport runs on host clock in sleep
// [RULE_17] function 1 in sleep: illegal, wakeup
// [RULE_18] stay awake for set interval after wakeup
// [RULE_19] host wakeup, ready interrupt select bits
// [RULE_20] sample on rising, drive on falling, msb first
// [RULE_21] error byte zero on success, else nonzero
package hsbp_pkg;

  // timing
  localparam int CLK_FREQ_MHZ     = 250;
  localparam int WAKE_HOLD_US     = 1000;
  localparam int WAKE_HOLD_CYCLES = WAKE_HOLD_US * CLK_FREQ_MHZ;
  localparam int BUF_AW_DEF       = 10;

  // bit counts of each field, as last index
  localparam logic [4:0] CNT_CMD_LAST  = 5'h07;
  localparam logic [4:0] CNT_ADDR_LAST = 5'h17;
  localparam logic [4:0] CNT_LEN_LAST  = 5'h0F;
  localparam logic [4:0] CNT_WORD_LAST = 5'h0F;
  localparam logic [2:0] CNT_BYTE_LAST = 3'h7;

  // command fields
  localparam int CMD_BURST_BIT = 7;
  localparam int CMD_WRITE_BIT = 6;

  // address spaces in address bits 23:16
  localparam logic [7:0] SPACE_F0    = 8'h00;
  localparam logic [7:0] SPACE_ACCEL = 8'h01;
  localparam logic [7:0] SPACE_CPU   = 8'h02;
  localparam logic [7:0] SPACE_F1    = 8'h03;
  localparam logic [7:0] SPACE_BUF   = 8'h80;

  // function 0 registers
  localparam logic [15:0] F0_CTRL   = 16'h0000;
  localparam logic [15:0] F0_PAD    = 16'h0001;
  localparam logic [15:0] F0_STATUS = 16'h0002;
  localparam int CTRL_LFE_BIT  = 0;
  localparam int CTRL_HWK_BIT  = 1;
  localparam int CTRL_RIS_BIT  = 2;
  localparam int STAT_FAIL_BIT = 8;
  localparam logic [3:0] PAD_RST = 4'h0;

  // error byte codes
  localparam logic [7:0] ERR_OK      = 8'h00;
  localparam logic [7:0] ERR_ILLEGAL = 8'h01;
  localparam logic [7:0] ERR_SPACE   = 8'h02;
  localparam logic [7:0] ERR_RANGE   = 8'h04;
  localparam logic [7:0] ERR_NORESP  = 8'h08;

  typedef enum logic [1:0] {REQ_REG_WR, REQ_REG_RD, REQ_BUF_WR, REQ_BUF_RD} hsbp_req_kind_t;

  typedef struct packed {
    hsbp_req_kind_t kind;
    logic [23:0]    addr;
    logic [15:0]    data;
  } hsbp_req_t;

  typedef struct packed {
    logic       lfe;
    logic       hwk;
    logic       ris;
    logic [3:0] pad;
  } hsbp_cfg_t;

endpackage : hsbp_pkg

// ==== verilog/hsbp_top.sv ====
// host serial burst port: link logic on the host clock, core side on clk
`timescale 1ns/1ps
module hsbp_top #(
  parameter int WAKE_HOLD_CYCLES = hsbp_pkg::WAKE_HOLD_CYCLES,
  parameter int BUF_AW           = hsbp_pkg::BUF_AW_DEF
) (
  // core clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // shared card pins
  input  wire logic        shared_pin_clk,
  input  wire logic        host_chip_select_n,
  input  wire logic        shared_pin_cmd,
  output logic             shared_pin_d0,
  output logic             shared_pin_d0_oe,
  output logic             shared_pin_d1,
  output logic             shared_pin_d1_oe,
  // mode and power
  input  wire logic        protocol_enable,
  input  wire logic        deep_sleep,
  output logic             stay_awake,
  output logic             host_wakeup,
  // register spaces outside function 0
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [23:0]      reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rdata
);

  localparam int HOLD_W = $clog2(WAKE_HOLD_CYCLES + 1);

  if (BUF_AW < 1 || BUF_AW > 16) begin : g_chk_aw
    $error("BUF_AW must lie in 1..16");
  end
  if (WAKE_HOLD_CYCLES < 1) begin : g_chk_hold
    $error("WAKE_HOLD_CYCLES must be at least 1");
  end

  typedef enum logic [3:0] {
    ST_CMD, ST_ADDR, ST_LEN, ST_WDATA, ST_PAD, ST_ERR, ST_RDATA, ST_BWDATA, ST_BRDATA, ST_DONE
  } hsbp_state_t;

  function automatic logic in_rng(input logic [23:0] a);
    in_rng = (a[23:16] == hsbp_pkg::SPACE_BUF) && ((a[15:0] >> BUF_AW) == 16'h0000);
  endfunction : in_rng

  function automatic logic [7:0] err_code(input logic [7:0] cmd, input logic [23:0] a,
                                          input logic ds);
    logic [7:0] sp;
    sp = a[23:16];
    if (cmd[hsbp_pkg::CMD_BURST_BIT]) begin
      if (sp != hsbp_pkg::SPACE_BUF) err_code = hsbp_pkg::ERR_SPACE; // [RULE_07]
      else if (!in_rng(a)) err_code = hsbp_pkg::ERR_RANGE;
      else err_code = hsbp_pkg::ERR_OK;
    end else if (sp == hsbp_pkg::SPACE_F1 && ds) begin
      err_code = hsbp_pkg::ERR_ILLEGAL; // [RULE_17]
    end else if (sp == hsbp_pkg::SPACE_F0 || sp == hsbp_pkg::SPACE_ACCEL ||
                 sp == hsbp_pkg::SPACE_CPU || sp == hsbp_pkg::SPACE_F1) begin
      err_code = hsbp_pkg::ERR_OK; // [RULE_21]
    end else begin
      err_code = hsbp_pkg::ERR_SPACE; // [RULE_07]
    end
  endfunction : err_code

  // link domain: synchronisers
  logic               rst_m_q, rst_s_q;
  logic               ds_m_q, ds_s_q;
  logic               en_m_q, en_s_q;
  logic               ack_m_q, ack_s_q;
  // link domain: frame state, cleared by chip select release
  hsbp_state_t        st_q, st_d;
  logic [4:0]         cnt_q, cnt_d;
  logic [23:0]        sh_q, sh_d;
  logic [7:0]         cmd_q, cmd_d;
  logic [23:0]        addr_q, addr_d;
  logic [15:0]        len_q, len_d;
  logic               len_on_q, len_on_d;
  logic [7:0]         err_q, err_d;
  logic [3:0]         pad_q, pad_d;
  logic [15:0]        tx_q, tx_d;
  logic               miso_q, miso_d;
  logic               d0_oe_q, d0_oe_d;
  // link domain: function 0 state and crossings out
  hsbp_pkg::hsbp_cfg_t cfg_q, cfg_d;
  logic               fail_q, fail_d;
  logic [7:0]         last_err_q, last_err_d;
  logic               req_tgl_q, req_tgl_d;
  hsbp_pkg::hsbp_req_t req_q, req_d;
  logic               wake_tgl_q, wake_tgl_d;
  // link domain events
  hsbp_pkg::hsbp_req_t post;
  logic               ev_post, ev_f0wr, ev_fail, ev_wake;
  logic [7:0]         fail_code;
  logic               go_body, go_err, ld_rd;
  logic               ack_ok, active_q, active_d;
  logic [15:0]        f0_rdata;
  // core domain
  logic               req_m_q, req_s_q, wake_m_q, wake_s_q;
  logic               fail_m_q, fail_s_q, ris_m_q, ris_s_q, hwk_m_q, hwk_s_q;
  logic               req_seen_q, req_seen_d;
  logic               wake_seen_q, wake_seen_d;
  logic               reg_wr_q, reg_wr_d;
  logic               reg_rd_q, reg_rd_d;
  logic [23:0]        reg_addr_q, reg_addr_d;
  logic [15:0]        reg_wdata_q, reg_wdata_d;
  logic               rd_wait_q, rd_wait_d;
  logic [15:0]        rsp_data_q, rsp_data_d;
  logic               ack_tgl_q, ack_tgl_d;
  logic [HOLD_W-1:0]  hold_q, hold_d;
  logic               stay_q, stay_d;
  logic               int_q, int_d;
  logic               int_oe_q, int_oe_d;
  logic               hwk_q, hwk_d;
  logic               mem_we;
  logic [7:0]         mem_q [2**BUF_AW];

  // ---------------- link domain ----------------
  always_ff @(posedge shared_pin_clk) begin
    rst_m_q <= rst;
    rst_s_q <= rst_m_q;
    ds_m_q  <= deep_sleep;
    ds_s_q  <= ds_m_q;
    en_m_q  <= protocol_enable;
    en_s_q  <= en_m_q;
    ack_m_q <= ack_tgl_q;
    ack_s_q <= ack_m_q;
  end

  assign ack_ok   = (ack_s_q == req_tgl_q);
  assign active_q = !len_on_q || (len_q != 16'h0000); // [RULE_14]
  assign active_d = !len_on_d || (len_d != 16'h0000);

  always_comb begin
    f0_rdata = 16'h0000;
    case (addr_q[15:0])
      hsbp_pkg::F0_CTRL: begin
        f0_rdata[hsbp_pkg::CTRL_LFE_BIT] = cfg_q.lfe;
        f0_rdata[hsbp_pkg::CTRL_HWK_BIT] = cfg_q.hwk;
        f0_rdata[hsbp_pkg::CTRL_RIS_BIT] = cfg_q.ris;
      end
      hsbp_pkg::F0_PAD:    f0_rdata[3:0] = cfg_q.pad;
      hsbp_pkg::F0_STATUS: f0_rdata = {7'h00, fail_q, last_err_q};
      default:             f0_rdata = 16'h0000;
    endcase
  end

  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q + 5'h01;
    sh_d      = {sh_q[22:0], shared_pin_cmd}; // [RULE_20]
    cmd_d     = cmd_q;
    addr_d    = addr_q;
    len_d     = len_q;
    len_on_d  = len_on_q;
    err_d     = err_q;
    pad_d     = pad_q;
    tx_d      = tx_q;
    go_body   = 1'b0;
    go_err    = 1'b0;
    ld_rd     = 1'b0;
    ev_post   = 1'b0;
    ev_f0wr   = 1'b0;
    ev_fail   = 1'b0;
    ev_wake   = 1'b0;
    fail_code = hsbp_pkg::ERR_OK;
    post      = '0;
    case (st_q)
      ST_CMD: if (cnt_q == hsbp_pkg::CNT_CMD_LAST) begin
        cmd_d = sh_d[7:0]; // [RULE_02]
        cnt_d = 5'h00;
        st_d  = en_s_q ? ST_ADDR : ST_DONE; // [RULE_01]
      end
      ST_ADDR: if (cnt_q == hsbp_pkg::CNT_ADDR_LAST) begin
        addr_d  = sh_d;
        cnt_d   = 5'h00;
        err_d   = err_code(cmd_q, sh_d, ds_s_q); // [RULE_16]
        ev_wake = (sh_d[23:16] == hsbp_pkg::SPACE_F1) && ds_s_q; // [RULE_17]
        if (cmd_q[hsbp_pkg::CMD_BURST_BIT] && cfg_q.lfe) st_d = ST_LEN; // [RULE_10]
        else go_body = 1'b1;
      end
      ST_LEN: if (cnt_q == hsbp_pkg::CNT_LEN_LAST) begin
        len_d    = sh_d[15:0]; // [RULE_08]
        len_on_d = 1'b1;
        cnt_d    = 5'h00;
        go_body  = 1'b1;
      end
      ST_WDATA: if (cnt_q == hsbp_pkg::CNT_WORD_LAST) begin
        cnt_d     = 5'h00;
        st_d      = ST_ERR;
        tx_d      = {err_q, 8'h00}; // [RULE_04]
        post.kind = hsbp_pkg::REQ_REG_WR;
        post.addr = addr_q;
        post.data = sh_d[15:0]; // [RULE_03]
        if (err_q == hsbp_pkg::ERR_OK) begin
          if (addr_q[23:16] == hsbp_pkg::SPACE_F0) ev_f0wr = 1'b1;
          else ev_post = 1'b1;
        end
      end
      ST_PAD: if (cnt_q[2:0] == hsbp_pkg::CNT_BYTE_LAST) begin
        cnt_d = 5'h00;
        pad_d = pad_q - 4'h1;
        if (pad_q == 4'h1) go_err = 1'b1; // [RULE_11]
      end
      ST_ERR: if (cnt_q[2:0] == hsbp_pkg::CNT_BYTE_LAST) begin
        cnt_d = 5'h00;
        if (cmd_q[hsbp_pkg::CMD_BURST_BIT]) begin
          st_d  = ST_BRDATA;
          ld_rd = (err_q == hsbp_pkg::ERR_OK); // [RULE_12]
          tx_d  = 16'h0000;
        end else if (cmd_q[hsbp_pkg::CMD_WRITE_BIT]) begin
          st_d = ST_DONE;
          tx_d = 16'h0000;
        end else begin
          st_d = ST_RDATA; // [RULE_05]
          if (err_q != hsbp_pkg::ERR_OK) tx_d = 16'h0000;
          else if (addr_q[23:16] == hsbp_pkg::SPACE_F0) tx_d = f0_rdata;
          else if (ack_ok) tx_d = rsp_data_q;
          else begin
            tx_d      = 16'h0000;
            ev_fail   = 1'b1;
            fail_code = hsbp_pkg::ERR_NORESP;
          end
        end
      end
      ST_RDATA: if (cnt_q == hsbp_pkg::CNT_WORD_LAST) begin
        cnt_d = 5'h00;
        st_d  = ST_DONE;
        tx_d  = 16'h0000;
      end
      ST_BWDATA: if (cnt_q[2:0] == hsbp_pkg::CNT_BYTE_LAST) begin
        cnt_d = 5'h00;
        if (active_q) begin // [RULE_09]
          if (in_rng(addr_q)) begin
            ev_post   = 1'b1; // [RULE_08]
            post.kind = hsbp_pkg::REQ_BUF_WR;
            post.addr = addr_q;
            post.data = {8'h00, sh_d[7:0]};
            addr_d    = addr_q + 24'h000001;
            if (len_on_q) len_d = len_q - 16'h0001;
          end else begin
            ev_fail   = 1'b1; // [RULE_15]
            fail_code = hsbp_pkg::ERR_RANGE;
          end
        end
      end
      ST_BRDATA: if (cnt_q[2:0] == hsbp_pkg::CNT_BYTE_LAST) begin
        cnt_d = 5'h00;
        ld_rd = (err_q == hsbp_pkg::ERR_OK); // [RULE_12]
        tx_d  = 16'h0000;
      end
      ST_DONE: cnt_d = cnt_q;
      default: st_d = ST_DONE;
    endcase

    if (go_body) begin
      if (err_d != hsbp_pkg::ERR_OK) begin
        ev_fail   = 1'b1; // [RULE_15]
        fail_code = err_d;
      end
      if (cmd_q[hsbp_pkg::CMD_WRITE_BIT]) begin
        if (!cmd_q[hsbp_pkg::CMD_BURST_BIT]) st_d = ST_WDATA; // [RULE_06]
        else if (err_d == hsbp_pkg::ERR_OK) st_d = ST_BWDATA;
        else st_d = ST_DONE;
      end else begin
        pad_d = cfg_q.pad; // [RULE_11]
        if (cfg_q.pad == 4'h0) go_err = 1'b1;
        else begin
          st_d = ST_PAD;
          tx_d = 16'h0000; // [RULE_05]
        end
        if (!cmd_q[hsbp_pkg::CMD_BURST_BIT] && err_d == hsbp_pkg::ERR_OK &&
            addr_d[23:16] != hsbp_pkg::SPACE_F0) begin
          ev_post   = 1'b1;
          post.kind = hsbp_pkg::REQ_REG_RD;
          post.addr = addr_d;
        end
      end
    end

    if (go_err) begin
      st_d = ST_ERR;
      tx_d = {err_d, 8'h00}; // [RULE_12]
      if (cmd_q[hsbp_pkg::CMD_BURST_BIT] && err_d == hsbp_pkg::ERR_OK && active_d &&
          in_rng(addr_d)) begin
        ev_post   = 1'b1; // [RULE_13]
        post.kind = hsbp_pkg::REQ_BUF_RD;
        post.addr = addr_d;
      end
    end

    if (ld_rd && active_q) begin
      if (in_rng(addr_q) && ack_ok) begin
        tx_d   = {rsp_data_q[7:0], 8'h00}; // [RULE_13]
        addr_d = addr_q + 24'h000001;
        if (len_on_q) len_d = len_q - 16'h0001;
        if (in_rng(addr_d)) begin
          ev_post   = 1'b1;
          post.kind = hsbp_pkg::REQ_BUF_RD;
          post.addr = addr_d;
        end
      end else begin
        ev_fail   = 1'b1; // [RULE_15]
        fail_code = in_rng(addr_q) ? hsbp_pkg::ERR_NORESP : hsbp_pkg::ERR_RANGE;
      end
    end

    // a reset seen on the host clock aborts the frame without side effects
    if (rst_s_q) begin
      st_d    = ST_DONE;
      ev_post = 1'b0;
      ev_f0wr = 1'b0;
      ev_fail = 1'b0;
      ev_wake = 1'b0;
    end
  end

  // chip select release is the only frame end the host clock guarantees
  always_ff @(posedge shared_pin_clk or posedge host_chip_select_n) begin
    if (host_chip_select_n) begin // [RULE_14]
      st_q     <= ST_CMD;
      cnt_q    <= 5'h00;
      sh_q     <= 24'h000000;
      cmd_q    <= 8'h00;
      addr_q   <= 24'h000000;
      len_q    <= 16'h0000;
      len_on_q <= 1'b0;
      err_q    <= 8'h00;
      pad_q    <= 4'h0;
      tx_q     <= 16'h0000;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      cmd_q    <= cmd_d;
      addr_q   <= addr_d;
      len_q    <= len_d;
      len_on_q <= len_on_d;
      err_q    <= err_d;
      pad_q    <= pad_d;
      tx_q     <= tx_d;
    end
  end

  always_comb begin
    miso_d  = tx_q[4'hF - cnt_q[3:0]]; // [RULE_20]
    // kept off through the command: the enable sync may still be stale then
    d0_oe_d = en_s_q && (st_q != ST_CMD); // [RULE_01]
  end

  always_ff @(negedge shared_pin_clk or posedge host_chip_select_n) begin
    if (host_chip_select_n) begin
      miso_q  <= 1'b0;
      d0_oe_q <= 1'b0;
    end else begin
      miso_q  <= miso_d;
      d0_oe_q <= d0_oe_d;
    end
  end

  always_comb begin
    cfg_d      = cfg_q;
    fail_d     = fail_q;
    last_err_d = last_err_q;
    req_tgl_d  = req_tgl_q;
    req_d      = req_q;
    wake_tgl_d = wake_tgl_q;
    if (ev_f0wr) begin
      case (addr_q[15:0])
        hsbp_pkg::F0_CTRL: begin
          cfg_d.lfe = post.data[hsbp_pkg::CTRL_LFE_BIT]; // [RULE_10]
          cfg_d.hwk = post.data[hsbp_pkg::CTRL_HWK_BIT]; // [RULE_19]
          cfg_d.ris = post.data[hsbp_pkg::CTRL_RIS_BIT];
        end
        hsbp_pkg::F0_PAD:    cfg_d.pad = post.data[3:0];
        hsbp_pkg::F0_STATUS: if (post.data[hsbp_pkg::STAT_FAIL_BIT]) fail_d = 1'b0;
        default:             cfg_d = cfg_q;
      endcase
    end
    if (ev_fail) begin
      fail_d     = 1'b1; // [RULE_15]
      last_err_d = fail_code;
    end
    if (ev_post) begin
      req_tgl_d = ~req_tgl_q;
      req_d     = post;
    end
    if (ev_wake) wake_tgl_d = ~wake_tgl_q; // [RULE_17]
    if (rst_s_q) begin
      cfg_d      = '0; // [RULE_10]
      cfg_d.pad  = hsbp_pkg::PAD_RST;
      fail_d     = 1'b0;
      last_err_d = hsbp_pkg::ERR_OK;
      req_tgl_d  = 1'b0;
      req_d      = '0;
      wake_tgl_d = 1'b0;
    end
  end

  always_ff @(posedge shared_pin_clk) begin
    cfg_q      <= cfg_d;
    fail_q     <= fail_d;
    last_err_q <= last_err_d;
    req_tgl_q  <= req_tgl_d;
    req_q      <= req_d;
    wake_tgl_q <= wake_tgl_d;
  end

  // ---------------- core domain ----------------
  always_ff @(posedge clk) begin
    req_m_q  <= req_tgl_q;
    req_s_q  <= req_m_q;
    wake_m_q <= wake_tgl_q;
    wake_s_q <= wake_m_q;
    fail_m_q <= fail_q;
    fail_s_q <= fail_m_q;
    ris_m_q  <= cfg_q.ris;
    ris_s_q  <= ris_m_q;
    hwk_m_q  <= cfg_q.hwk;
    hwk_s_q  <= hwk_m_q;
  end

  always_comb begin
    req_seen_d  = req_s_q;
    wake_seen_d = wake_s_q;
    reg_wr_d    = 1'b0;
    reg_rd_d    = 1'b0;
    reg_addr_d  = reg_addr_q;
    reg_wdata_d = reg_wdata_q;
    rd_wait_d   = 1'b0;
    rsp_data_d  = rsp_data_q;
    ack_tgl_d   = ack_tgl_q;
    mem_we      = 1'b0;
    if (req_s_q != req_seen_q) begin
      case (req_q.kind)
        hsbp_pkg::REQ_REG_WR: begin
          reg_wr_d    = 1'b1; // [RULE_03]
          reg_addr_d  = req_q.addr;
          reg_wdata_d = req_q.data;
          ack_tgl_d   = ~ack_tgl_q;
        end
        hsbp_pkg::REQ_REG_RD: begin
          reg_rd_d   = 1'b1;
          reg_addr_d = req_q.addr;
          rd_wait_d  = 1'b1;
        end
        hsbp_pkg::REQ_BUF_WR: begin
          mem_we    = 1'b1;
          ack_tgl_d = ~ack_tgl_q;
        end
        hsbp_pkg::REQ_BUF_RD: begin
          rsp_data_d = {8'h00, mem_q[req_q.addr[BUF_AW-1:0]]}; // [RULE_13]
          ack_tgl_d  = ~ack_tgl_q;
        end
        default: ack_tgl_d = ~ack_tgl_q;
      endcase
    end
    if (rd_wait_q) begin
      rsp_data_d = reg_rdata;
      ack_tgl_d  = ~ack_tgl_q;
    end
    if (wake_s_q != wake_seen_q) hold_d = HOLD_W'(WAKE_HOLD_CYCLES); // [RULE_18]
    else if (hold_q != '0) hold_d = hold_q - HOLD_W'(1);
    else hold_d = hold_q;
    stay_d   = (hold_d != '0);
    int_d    = fail_s_q | (ris_s_q & ~deep_sleep); // [RULE_15]
    int_oe_d = protocol_enable; // [RULE_01]
    hwk_d    = hwk_s_q; // [RULE_19]
    if (rst) begin
      reg_wr_d    = 1'b0;
      reg_rd_d    = 1'b0;
      reg_addr_d  = 24'h000000;
      reg_wdata_d = 16'h0000;
      rd_wait_d   = 1'b0;
      rsp_data_d  = 16'h0000;
      ack_tgl_d   = 1'b0;
      mem_we      = 1'b0;
      hold_d      = '0;
      stay_d      = 1'b0;
      int_d       = 1'b0;
      int_oe_d    = 1'b0;
      hwk_d       = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    req_seen_q  <= req_seen_d;
    wake_seen_q <= wake_seen_d;
    reg_wr_q    <= reg_wr_d;
    reg_rd_q    <= reg_rd_d;
    reg_addr_q  <= reg_addr_d;
    reg_wdata_q <= reg_wdata_d;
    rd_wait_q   <= rd_wait_d;
    rsp_data_q  <= rsp_data_d;
    ack_tgl_q   <= ack_tgl_d;
    hold_q      <= hold_d;
    stay_q      <= stay_d;
    int_q       <= int_d;
    int_oe_q    <= int_oe_d;
    hwk_q       <= hwk_d;
    if (mem_we) mem_q[req_q.addr[BUF_AW-1:0]] <= req_q.data[7:0];
  end

  // outputs, each straight from a flop
  assign shared_pin_d0    = miso_q;
  assign shared_pin_d0_oe = d0_oe_q;
  assign shared_pin_d1    = int_q;
  assign shared_pin_d1_oe = int_oe_q;
  assign stay_awake       = stay_q;
  assign host_wakeup      = hwk_q;
  assign reg_wr           = reg_wr_q;
  assign reg_rd           = reg_rd_q;
  assign reg_addr         = reg_addr_q;
  assign reg_wdata        = reg_wdata_q;

endmodule : hsbp_top

// ==== dv/hsbp_assertions.sv ====
// concurrent checks, on the core clock, of the core-side and shared card pins of the host serial burst port
`timescale 1ns/1ps
module hsbp_assertions #(
  parameter int WAKE_HOLD_CYCLES = 20,
  parameter int BUF_AW           = 4
) (
  // core clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // shared card pins
  input wire logic        shared_pin_clk,
  input wire logic        host_chip_select_n,
  input wire logic        shared_pin_cmd,
  input wire logic        shared_pin_d0,
  input wire logic        shared_pin_d0_oe,
  input wire logic        shared_pin_d1,
  input wire logic        shared_pin_d1_oe,
  // mode and power
  input wire logic        protocol_enable,
  input wire logic        deep_sleep,
  input wire logic        stay_awake,
  input wire logic        host_wakeup,
  // register spaces
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [23:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_awake8; stay_awake [*8]; endsequence
  a_wr_one_pulse: assert property (reg_wr |=> !reg_wr) else $error("long write strobe");
  a_rd_one_pulse: assert property (reg_rd |=> !reg_rd) else $error("long read strobe");
  a_wr_rd_excl: assert property (!(reg_wr && reg_rd)) else $error("read with write");
  a_wr_held: assert property (
    reg_wr |=> $stable(reg_addr) && $stable(reg_wdata)) else $error("write data not held");
  a_no_buf_reg: assert property (
    (reg_wr || reg_rd) |-> reg_addr[23:16] != hsbp_pkg::SPACE_BUF) else $error("strobe to buffer");
  a_f1_asleep: assert property (
    (reg_wr || reg_rd) && reg_addr[23:16] == hsbp_pkg::SPACE_F1 |-> !deep_sleep)
    else $error("function 1 reached in sleep");
  a_miso_idle: assert property (
    host_chip_select_n && $past(host_chip_select_n) |-> !shared_pin_d0 && !shared_pin_d0_oe)
    else $error("data pin driven while deselected");
  a_int_oe: assert property (
    !$past(rst) |-> shared_pin_d1_oe == $past(protocol_enable)) else $error("interrupt enable");
  a_oe_needs_en: assert property (shared_pin_d0_oe |-> shared_pin_d1_oe)
    else $error("data pin driven while protocol off");
  a_wake_hold: assert property ($rose(stay_awake) |-> s_awake8) else $error("short wake");
endmodule : hsbp_assertions

bind hsbp_top hsbp_assertions #(.WAKE_HOLD_CYCLES(WAKE_HOLD_CYCLES), .BUF_AW(BUF_AW))
  hsbp_assertions_i (.clk(clk), .rst(rst), .shared_pin_clk(shared_pin_clk),
  .host_chip_select_n(host_chip_select_n), .shared_pin_cmd(shared_pin_cmd),
  .shared_pin_d0(shared_pin_d0), .shared_pin_d0_oe(shared_pin_d0_oe),
  .shared_pin_d1(shared_pin_d1), .shared_pin_d1_oe(shared_pin_d1_oe),
  .protocol_enable(protocol_enable), .deep_sleep(deep_sleep), .stay_awake(stay_awake),
  .host_wakeup(host_wakeup), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

// ==== dv/hsbp_host_model.sv ====
// host-side serial master that shifts whole frames through the port
`timescale 1ns/1ps
module hsbp_host_model (
  // serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // select stays high: only used so the link side sees its reset
  task automatic idle(input int n);
    repeat (2 * n) #16 sclk = ~sclk;
  endtask : idle
  // msb first; sampled just before the rising edge, data pin moves on falling
  task automatic xfer(input int n, input logic [127:0] tx, output logic [127:0] rx);
    rx = '0;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = tx[i];
      #16 rx = {rx[126:0], miso};
      sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    mosi = ~mosi;
  endtask : xfer
endmodule : hsbp_host_model

// ==== dv/hsbp_top_tb.sv ====
// self-checking bench of the host serial burst port
`timescale 1ns/1ps
module hsbp_top_tb;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         deep_sleep = 1'b0;
  logic         pe = 1'b1;
  logic [15:0]  reg_rdata = 16'h0000;
  logic         sclk, cs_n, mosi, d0, d0_oe, d1, d1_oe, awake, hwk, reg_wr, reg_rd;
  logic         woke = 1'b0;
  logic [23:0]  reg_addr;
  logic [15:0]  reg_wdata;
  logic [127:0] rx;
  logic [39:0]  exp_q[$];
  int           mismatches = 0;
  int           comparisons = 0;
  int           seed = 73493;
  always #2 clk = ~clk;
  hsbp_top #(.WAKE_HOLD_CYCLES(20), .BUF_AW(4)) hsbp_top_i (.clk(clk), .rst(rst),
    .shared_pin_clk(sclk), .host_chip_select_n(cs_n), .shared_pin_cmd(mosi),
    .shared_pin_d0(d0), .shared_pin_d0_oe(d0_oe), .shared_pin_d1(d1), .shared_pin_d1_oe(d1_oe),
    .protocol_enable(pe), .deep_sleep(deep_sleep), .stay_awake(awake), .host_wakeup(hwk),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  hsbp_host_model hsbp_host_model_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(d0));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // every strobe takes the oldest note; an unexpected strobe counts as a miss
  always @(negedge clk) begin
    if (awake) woke <= 1'b1;
    if (!rst && (reg_wr | reg_rd) !== 1'b0) begin
      if (exp_q.size() == 0) check(1, 0);
      else check({reg_addr, reg_wr ? reg_wdata : 16'h0000}, exp_q.pop_front());
    end
  end
  task automatic frame(input int n, input logic [127:0] tx);
    @(posedge clk);
    #1 hsbp_host_model_i.xfer(n, tx, rx);
    repeat (40) @(posedge clk);
  endtask : frame
  task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic [7:0] err);
    if (err == 8'h00 && a[23:16] != 8'h00) exp_q.push_back({a, d});
    frame(56, {8'h40, a, d, 8'h00});
    check(rx[7:0], err);
  endtask : wr
  task automatic rd(input logic [23:0] a, input int pad, input logic [23:0] exp);
    if (a[23:16] != 8'h00) exp_q.push_back({a, 16'h0000});
    frame(56 + 8 * pad, 128'({8'h00, a}) << (24 + 8 * pad));
    check(rx[23:0], exp);
    check(64'(rx >> 24) & ((64'h1 << (8 * pad)) - 64'h1), 64'h0);
  endtask : rd
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  initial begin
    logic [15:0] d;
    fork hsbp_host_model_i.idle(5); join_none
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (30) @(posedge clk);
    for (int k = 1; k < 4; k++) wr({8'(k), 16'h0004}, 16'($random(seed)), 8'h00);
    wr(24'h800000, 16'hFFFF, 8'h02);
    check(d1, 1'b1);
    wr(24'h000002, 16'h0100, 8'h00);
    check(d1, 1'b0);
    $display("test register writes done");
    d = 16'($random(seed));
    @(posedge clk) reg_rdata <= d;
    rd(24'h020010, 0, {8'h00, d});
    wr(24'h000001, 16'h0002, 8'h00);
    rd(24'h010020, 2, {8'h00, d});
    pe <= 1'b0;
    frame(72, 128'({8'h00, 24'h000001}) << 40);
    check({d1_oe, rx[23:0]}, 25'h0000000);
    pe <= 1'b1;
    $display("test register reads done");
    @(posedge clk) deep_sleep <= 1'b1;
    repeat (10) @(posedge clk);
    check(woke, 1'b0);
    wr(24'h030004, 16'h5555, 8'h01);
    check(woke, 1'b1);
    rd(24'h000001, 2, {8'h00, 16'h0002});
    @(posedge clk) deep_sleep <= 1'b0;
    $display("test deep sleep done");
    frame(48, {8'hC0, 24'h800000, 16'hA53C});
    wr(24'h000002, 16'h0100, 8'h00);
    wr(24'h000000, 16'h0007, 8'h00);
    check({hwk, d1}, 2'b11);
    frame(56, {8'hC0, 24'h800000, 16'h0000, 8'h77});
    frame(88, 128'({8'h80, 24'h800000, 16'h0002}) << 40);
    check(rx[39:0], {16'h0000, 8'h00, 16'hA53C});
    $display("test bursts done");
    check(exp_q.size(), 0);
    summarize();
  end
endmodule : hsbp_top_tb
